// ### core/psx_translator.sv
`timescale 1ns/1ps
module psx_translator
    import psx_pkg::*;
(
    // Clock and reset
    input  wire logic              i_ref_clk,
    input  wire logic              i_nrst,
    // Host request
    input  wire logic              i_req_valid,
    input  wire logic              i_req_write,
    input  wire logic [SYS_AW-1:0] i_req_addr,
    // Extension register value
    input  wire logic [7:0]        i_io_config_extension_register,
    // PCI address phase
    output logic                   o_hit,
    output logic                   o_addr_valid,
    output logic [3:0]             o_cmd,
    output logic [31:0]            o_ad,
    output logic [3:0]             o_be_n,
    output logic                   o_burst2,
    output logic                   o_illegal,
    output logic                   o_is_config
);
    typedef struct packed {
        logic        valid;
        logic [3:0]  cmd;
        logic [31:0] ad;
        logic [3:0]  be_n;
        logic        burst2;
        logic        illegal;
        logic        is_config;
    } psx_state_s;

    psx_state_s state_q;
    psx_state_s state_d;

    logic [4:0]         space;
    logic               sel_io;
    logic               sel_cfg;
    logic [3:0]         be_n;
    logic [2:0]         ad_low;
    logic               len_illegal;
    logic               quad;
    logic [IDSEL_W-1:0] idsel;
    logic [7:0]         io_high;

    assign space   = i_req_addr[SPACE_HI:SPACE_LO];
    assign sel_io  = (space == SPACE_SPARSE_IO);
    assign sel_cfg = (space == SPACE_CONFIG);
    assign o_hit   = i_req_valid & (sel_io | sel_cfg);

    // Selects fixed zero only for the lowest region
    assign io_high = (i_req_addr[EXT_SEL_HI:EXT_SEL_LO] == '0)
                   ? FIXED_ZERO_EXTENSION
                   : i_io_config_extension_register;

    psx_byte_enable u_byte_enable (
        .i_len     (i_req_addr[LEN_HI:LEN_LO]),
        .i_ofs     (i_req_addr[OFS_HI:OFS_LO]),
        .i_lane_hi (i_req_addr[LANE_HI_BIT]),
        .o_be_n    (be_n),
        .o_ad_low  (ad_low),
        .o_illegal (len_illegal),
        .o_quad    (quad)
    );

    psx_idsel_decode u_idsel_decode (
        .i_dev   (i_req_addr[DEV_HI:DEV_LO]),
        .o_idsel (idsel)
    );

    always_comb
    begin
        state_d       = '0;
        state_d.cmd   = CMD_NONE;
        state_d.be_n  = 4'hF;
        if (i_req_valid && sel_io)
        begin
            state_d.valid   = 1'b1;
            state_d.cmd     = i_req_write ? CMD_IO_WRITE : CMD_IO_READ;
            state_d.ad      = {io_high, i_req_addr[QW_HI:QW_LO], ad_low};
            state_d.be_n    = be_n;
            state_d.burst2  = quad;
            // Illegal combinations still run; only flagged
            state_d.illegal = len_illegal;
        end
        else if (i_req_valid && sel_cfg)
        begin
            state_d.valid     = 1'b1;
            state_d.is_config = 1'b1;
            state_d.cmd       = i_req_write ? CMD_CFG_WRITE : CMD_CFG_READ;
            state_d.be_n      = be_n;
            state_d.illegal   = len_illegal;
            state_d.ad[10:8]  = i_req_addr[FUNC_HI:FUNC_LO];
            state_d.ad[7:2]   = i_req_addr[REG_HI:REG_LO];
            state_d.ad[1:0]   = i_io_config_extension_register[1:0];
            if (i_io_config_extension_register[1:0] == CFG_TYPE_PRIMARY)
            begin
                // Bus number bits are not used here
                state_d.ad[31:11] = idsel;
            end
            else
            begin
                state_d.ad[31:24] = 8'h00;
                state_d.ad[23:16] = i_req_addr[BUS_HI:BUS_LO];
                state_d.ad[15:11] = i_req_addr[DEV_HI:DEV_LO];
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            state_q      <= '0;
            state_q.be_n <= 4'hF;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign o_addr_valid = state_q.valid;
    assign o_cmd        = state_q.cmd;
    assign o_ad         = state_q.ad;
    assign o_be_n       = state_q.be_n;
    assign o_burst2     = state_q.burst2;
    assign o_illegal    = state_q.illegal;
    assign o_is_config  = state_q.is_config;
endmodule

// ### core/psx_pkg.sv
package psx_pkg;
    // System address layout
    localparam int SYS_AW          = 34;
    localparam int SPACE_HI        = 33;
    localparam int SPACE_LO        = 29;
    localparam logic [4:0] SPACE_SPARSE_IO = 5'h0E;
    localparam logic [4:0] SPACE_CONFIG    = 5'h0F;
    // Sparse I/O fields
    localparam int QW_HI           = 28;
    localparam int QW_LO           = 8;
    localparam int EXT_SEL_HI      = 28;
    localparam int EXT_SEL_LO      = 23;
    localparam int LANE_HI_BIT     = 7;
    localparam int OFS_HI          = 6;
    localparam int OFS_LO          = 5;
    localparam int LEN_HI          = 4;
    localparam int LEN_LO          = 3;
    localparam logic [7:0] FIXED_ZERO_EXTENSION = 8'h00;
    // Configuration fields
    localparam int BUS_HI          = 28;
    localparam int BUS_LO          = 21;
    localparam int DEV_HI          = 20;
    localparam int DEV_LO          = 16;
    localparam int FUNC_HI         = 15;
    localparam int FUNC_LO         = 13;
    localparam int REG_HI          = 12;
    localparam int REG_LO          = 7;
    localparam logic [4:0] MAX_PRIMARY_DEV = 5'h14;
    localparam int IDSEL_W         = 21;
    localparam logic [1:0] CFG_TYPE_PRIMARY   = 2'h0;
    localparam logic [1:0] CFG_TYPE_SECONDARY = 2'h1;
    // Length encodings
    localparam logic [1:0] LEN_BYTE    = 2'h0;
    localparam logic [1:0] LEN_WORD    = 2'h1;
    localparam logic [1:0] LEN_TRIBYTE = 2'h2;
    localparam logic [1:0] LEN_LONG    = 2'h3;
    // PCI commands
    localparam logic [3:0] CMD_IO_READ   = 4'h2;
    localparam logic [3:0] CMD_IO_WRITE  = 4'h3;
    localparam logic [3:0] CMD_CFG_READ  = 4'hA;
    localparam logic [3:0] CMD_CFG_WRITE = 4'hB;
    localparam logic [3:0] CMD_NONE      = 4'h0;
endpackage

// ### core/psx_byte_enable.sv
`timescale 1ns/1ps
module psx_byte_enable
    import psx_pkg::*;
(
    // Length and offset
    input  wire logic [1:0] i_len,
    input  wire logic [1:0] i_ofs,
    input  wire logic       i_lane_hi,
    // Result
    output logic [3:0]      o_be_n,
    output logic [2:0]      o_ad_low,
    output logic            o_illegal,
    output logic            o_quad
);
    always_comb
    begin
        o_be_n    = 4'h0;
        o_illegal = 1'b0;
        o_quad    = 1'b0;
        o_ad_low  = {i_lane_hi, i_ofs};
        unique case (i_len)
            LEN_BYTE:    o_be_n = ~(4'h1 << i_ofs);
            LEN_WORD:
            begin
                o_be_n    = ~(4'h3 << i_ofs);
                o_illegal = (i_ofs == 2'h3);
            end
            LEN_TRIBYTE:
            begin
                o_be_n    = ~(4'h7 << i_ofs);
                o_illegal = i_ofs[1];
            end
            LEN_LONG:
            begin
                o_be_n = 4'h0;
                if (i_ofs == 2'h3)
                begin
                    o_quad   = 1'b1;
                    o_ad_low = 3'h0;
                end
                else
                begin
                    o_illegal = (i_ofs != 2'h0);
                end
            end
        endcase
    end
endmodule

// ### core/psx_idsel_decode.sv
`timescale 1ns/1ps
module psx_idsel_decode
    import psx_pkg::*;
(
    // Device number
    input  wire logic [4:0]         i_dev,
    // One-hot select lines ad[31:11]; all zero for device numbers above 20
    output logic [IDSEL_W-1:0]      o_idsel
);
    always_comb
    begin
        o_idsel = '0;
        if (i_dev <= MAX_PRIMARY_DEV)
        begin
            o_idsel[i_dev] = 1'b1;
        end
    end
endmodule

// ### dv/psx_translator_monitor.sv
`timescale 1ns/1ps
module psx_translator_monitor
    import psx_pkg::*;
(
    // Clock, reset and request
    input  wire logic              i_ref_clk,
    input  wire logic              i_nrst,
    input  wire logic              i_req_valid,
    input  wire logic              i_req_write,
    input  wire logic [SYS_AW-1:0] i_req_addr,
    input  wire logic [7:0]        i_io_config_extension_register,
    // Address phase
    input  wire logic              o_hit,
    input  wire logic              o_addr_valid,
    input  wire logic [3:0]        o_cmd,
    input  wire logic [31:0]       o_ad,
    input  wire logic [3:0]        o_be_n,
    input  wire logic              o_burst2,
    input  wire logic              o_illegal,
    input  wire logic              o_is_config
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);
    wire logic [4:0] sp = i_req_addr[SPACE_HI:SPACE_LO];
    wire logic [1:0] ty = i_io_config_extension_register[1:0];
    wire logic [4:0] dv = i_req_addr[DEV_HI:DEV_LO];
    sequence s_io; i_req_valid && sp == SPACE_SPARSE_IO; endsequence
    sequence s_cf; i_req_valid && sp == SPACE_CONFIG; endsequence
    property p_hit; o_hit == (i_req_valid && sp[4:1] == 4'h7); endproperty
    property p_cmd; s_io |=> o_addr_valid && o_cmd == {3'h1, $past(i_req_write)}; endproperty
    property p_qwa; s_io |=> o_ad[23:3] == $past(i_req_addr[28:8]); endproperty
    property p_ext;
        s_io |=> o_ad[31:24] == ($past(i_req_addr[28:23]) == 6'h00 ? FIXED_ZERO_EXTENSION
            : $past(i_io_config_extension_register));
    endproperty
    property p_qw; s_io ##0 i_req_addr[6:3] == 4'hF |=> o_burst2 && o_be_n == 4'h0; endproperty
    property p_cfg; s_cf |=> o_is_config && o_ad[10:0] == $past({i_req_addr[15:7], ty}); endproperty
    property p_sec; s_cf ##0 ty == 2'h1 |=> o_ad[31:11] == $past({8'h00, i_req_addr[28:16]}); endproperty
    property p_pri;
        s_cf ##0 ty == 2'h0 |=> o_ad[31:11] == $past(dv > 5'h14 ? 21'h0 : 21'h1 << dv);
    endproperty
    a_hit: assert property (p_hit) else $error("window decode wrong");
    a_cmd: assert property (p_cmd) else $error("io command wrong");
    a_qwa: assert property (p_qwa) else $error("quadword address wrong");
    a_ext: assert property (p_ext) else $error("upper io address wrong");
    a_qw: assert property (p_qw) else $error("quadword burst wrong");
    a_cfg: assert property (p_cfg) else $error("config low fields wrong");
    a_sec: assert property (p_sec) else $error("secondary fields wrong");
    a_pri: assert property (p_pri) else $error("device select wrong");
endmodule
bind psx_translator psx_translator_monitor i_psx_translator_monitor (.*);

// ### dv/psx_pci_target_model.sv
`timescale 1ns/1ps
module psx_pci_target_model
    import psx_pkg::*;
#(
    parameter int DEV_NUM = 10
)
(
    // Address phase seen on the bus
    input  wire logic        i_addr_valid,
    input  wire logic [3:0]  i_cmd,
    input  wire logic [31:0] i_ad,
    // Claims
    output logic             o_dev_sel,
    output logic             o_bridge_sel
);
    logic cf;
    assign cf = i_addr_valid && i_cmd[3:1] == 3'h5;
    assign o_dev_sel = cf && i_ad[1:0] == 2'h0 && i_ad[11 + DEV_NUM];
    assign o_bridge_sel = cf && i_ad[1:0] == 2'h1;
endmodule

// ### dv/testbench.sv
`timescale 1ns/1ps
module testbench;
    import psx_pkg::*;
    logic              clk = 1'b0;
    logic              nrst = 1'b0;
    logic              vld = 1'b0;
    logic              wr = 1'b0;
    logic [SYS_AW-1:0] addr = '0;
    logic [7:0]        ext = 8'h00;
    logic              hit, av, b2, ill, cfg, dsel, bsel;
    logic [3:0]        cmd, be_n;
    logic [31:0]       ad;
    int                n_fail = 0;
    int                compares = 0;
    logic              hit_seen = 1'b0;
    psx_translator i_psx_translator (.i_ref_clk(clk), .i_nrst(nrst), .i_req_valid(vld),
        .i_req_write(wr), .i_req_addr(addr), .i_io_config_extension_register(ext),
        .o_hit(hit), .o_addr_valid(av), .o_cmd(cmd), .o_ad(ad), .o_be_n(be_n),
        .o_burst2(b2), .o_illegal(ill), .o_is_config(cfg));
    psx_pci_target_model i_psx_pci_target_model (.i_addr_valid(av), .i_cmd(cmd), .i_ad(ad),
        .o_dev_sel(dsel), .o_bridge_sel(bsel));
    initial forever #50 clk = ~clk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // One request cycle; answer is settled at the following falling edge
    task automatic issue(input logic w, input logic [SYS_AW-1:0] a);
        @(negedge clk);
        vld = 1'b1;
        wr = w;
        addr = a;
        // Window hit is combinational; take it where the request has settled
        @(posedge clk);
        hit_seen = hit;
        @(negedge clk);
        vld = 1'b0;
    endtask
    task automatic t_lanes();
        logic [63:0] tab = 64'h0007_003B_019D_08CE;
        logic [15:0] bad = 16'h6C80;
        for (int i = 0; i < 16; i++)
        begin
            issue(i[0], 34'h1C0000080 | 34'(i << 3));
            chk(cmd, i[0] ? CMD_IO_WRITE : CMD_IO_READ);
            chk({av, ill}, {1'b1, bad[i]});
            chk(b2, i == 15);
            if (!bad[i])
            begin
                chk(be_n, tab[4*i +: 4]);
                chk(ad[2:0], i == 15 ? 3'h0 : {1'b1, 2'(i >> 2)});
            end
        end
        $display("lanes test done");
    endtask
    task automatic t_sparse();
        ext = 8'h5A;
        // Host side keeps to longword accesses here; no burst asked of I/O targets
        issue(1'b0, 34'h1C07FFF18);
        chk(ad[31:3], {8'h00, 21'h007FFF});
        chk(hit_seen, 1'b1);
        issue(1'b1, 34'h1DFFFFF18);
        chk(ad[31:3], {8'h5A, 21'h1FFFFF});
        chk({hit_seen, b2}, {1'b1, 1'b0});
        $display("sparse test done");
    endtask
    task automatic t_primary();
        ext = 8'hFC;
        for (int d = 0; d < 32; d++)
        begin
            issue(d[0], {5'h0F, 8'hA5, 5'(d), 3'h5, 6'h2A, 7'h18});
            chk(ad[31:11], d <= 20 ? 21'h1 << d : 21'h0);
            chk(ad[10:0], {3'h5, 6'h2A, 2'h0});
            chk(cmd, d[0] ? CMD_CFG_WRITE : CMD_CFG_READ);
            chk({cfg, hit_seen}, 2'h3);
            chk({be_n, dsel}, {4'h0, d == 10});
        end
        $display("primary test done");
    endtask
    task automatic t_secondary();
        ext = 8'h01;
        issue(1'b1, {5'h0F, 8'hC3, 5'h1F, 3'h2, 6'h15, 7'h00});
        chk(ad, {8'h00, 8'hC3, 5'h1F, 3'h2, 6'h15, 2'h1});
        chk({be_n, bsel}, {4'hE, 1'b1});
        $display("secondary test done");
    endtask
    task automatic t_refused();
        issue(1'b0, 34'h1BFFFFFF8);
        chk({av, cmd, be_n}, {1'b0, CMD_NONE, 4'hF});
        chk({hit_seen, cfg}, 2'h0);
        issue(1'b1, 34'h200000000);
        chk({av, cmd, be_n}, {1'b0, CMD_NONE, 4'hF});
        chk({hit_seen, cfg}, 2'h0);
        $display("refused test done");
    endtask
    initial
    begin
        repeat (12) @(negedge clk);
        nrst = 1'b1;
        t_lanes();
        t_sparse();
        t_primary();
        t_secondary();
        t_refused();
        give_verdict();
    end
endmodule
